// ===== common/brake_seq_defs.svh
// Timing constants and reset values for the holding brake sequencer
`ifndef BRAKE_SEQ_DEFS_SVH
`define BRAKE_SEQ_DEFS_SVH

`define CLK_HZ               20000000
`define MS_TICK_CYCLES       (`CLK_HZ / 1000)
`define RESET_FILTER_MS_DEF  120
`define REST_SPEED_RPM       30
`define SPEED_W              16
`define DELAY_W              16

`endif

// ===== common/brake_seq_pkg.sv
// Types shared by the holding brake sequencer
package brake_seq_pkg;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_WAIT_REST,
    ST_ON,
    ST_STOP_DELAY,
    ST_RUN_DELAY,
    ST_ALARM
  } seq_state_t;

  typedef enum logic [1:0] {
    DB_HOLD_DB,
    DB_FREE_DB,
    DB_HOLD_FREE,
    DB_FREE_FREE
  } stop_sel_t;

endpackage : brake_seq_pkg

// ===== hw/ms_tick_gen.sv
// Millisecond enable pulse divider
`timescale 1ns/1ns
`include "brake_seq_defs.svh"

module ms_tick_gen #(
  parameter int unsigned DIV = `MS_TICK_CYCLES
) (
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  output logic      tick_o
);
  logic [31:0] cnt_q;
  wire         wrap = (cnt_q == 32'(DIV - 1));

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q  <= 32'h0;
      tick_o <= 1'b0;
    end else begin
      cnt_q  <= wrap ? 32'h0 : cnt_q + 32'h1;
      tick_o <= wrap;
    end
  end
endmodule : ms_tick_gen

// ===== hw/reset_filter.sv
// Alarm reset input qualifier: must be held for a number of ms ticks
`timescale 1ns/1ns
`include "brake_seq_defs.svh"

module reset_filter #(
  parameter int unsigned W = `DELAY_W
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  input  wire logic         tick_i,
  input  wire logic         level_i,
  input  wire logic [W-1:0] hold_ms_i,
  output logic              pulse_o
);
  logic [W-1:0] cnt_q;
  logic         done_q;
  wire          reached = (cnt_q >= hold_ms_i);

  // One pulse per held assertion; release re-arms
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q   <= '0;
      done_q  <= 1'b0;
      pulse_o <= 1'b0;
    end else begin
      pulse_o <= 1'b0;
      if (!level_i) begin
        cnt_q  <= '0;
        done_q <= 1'b0;
      end else if (reached && !done_q) begin
        pulse_o <= 1'b1;
        done_q  <= 1'b1;
      end else if (tick_i && !reached) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule : reset_filter

// ===== hw/holding_brake_interlock_sequencer.sv
// Holding brake interlock sequencer: servo on/off, alarm and brake release timing
//
// Summary of operation
// - Brake release output asserts only after servo control requests brake release.
// - Servo off at standstill: wait stop brake delay, then brake and unpower.
// - Servo off running: brake and unpower at earlier of run delay or threshold.
// - Stopped sequence: servo on only once speed is about 30 r/min or less.
// - Running sequence: servo on only once speed is at or below threshold.
// - Servo on reasserted while decelerating is ignored until the motor rests.
// - At servo off the dynamic brake follows the stop selection setting.
// - Alarm in servo on: dynamic brake per selection, brake with running timing.
// - Main power loss while running raises an alarm and alarm sequencing.
// - Alarm reset recognised only after held for filter time, default 120 ms.
// - After alarm reset stay servo off; a fresh servo on is needed.
`timescale 1ns/1ns
`include "brake_seq_defs.svh"

module holding_brake_interlock_sequencer
  import brake_seq_pkg::*;
#(
  parameter int unsigned SPEED_W   = `SPEED_W,
  parameter int unsigned DELAY_W   = `DELAY_W,
  parameter int unsigned MS_CYCLES = `MS_TICK_CYCLES,
  parameter int unsigned REST_RPM  = `REST_SPEED_RPM
) (
  // Clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               rst_i,
  // Host commands
  input  wire logic               servo_on_cmd_i,
  input  wire logic               alarm_reset_i,
  input  wire logic               brake_release_req_i,
  // Drive status
  input  wire logic [SPEED_W-1:0] motor_speed_i,
  input  wire logic               alarm_i,
  input  wire logic               main_power_ok_i,
  // Configuration
  input  wire logic [DELAY_W-1:0] stop_brake_delay_i,
  input  wire logic [DELAY_W-1:0] run_brake_delay_i,
  input  wire logic [SPEED_W-1:0] brake_speed_threshold_i,
  input  wire logic [1:0]         servo_off_stop_select_i,
  input  wire logic [DELAY_W-1:0] alarm_reset_filter_time_i,
  // Outputs to power stage, brake and host
  output logic                    brake_release_output_o,
  output logic                    motor_power_o,
  output logic                    dynamic_brake_o,
  output logic                    servo_ready_o,
  output logic                    alarm_active_o
);

  // ==========================================================
  // Helpers
  // ==========================================================
  localparam logic [SPEED_W-1:0] REST_SPEED = SPEED_W'(REST_RPM);

  function automatic logic at_or_below(input logic [SPEED_W-1:0] spd,
                                       input logic [SPEED_W-1:0] lim);
    return spd <= lim;
  endfunction : at_or_below

  // Dynamic brake during deceleration (bit1=0) or after stop (bit0=0)
  function automatic logic db_on(input logic [1:0] sel, input logic stopped);
    return stopped ? !sel[0] : !sel[1];
  endfunction : db_on

  // ==========================================================
  // Sub-blocks
  // ==========================================================
  logic ms_tick;
  logic reset_pulse;

  ms_tick_gen #(
    .DIV (MS_CYCLES)
  ) u_tick (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .tick_o     (ms_tick)
  );

  reset_filter #(
    .W (DELAY_W)
  ) u_rst_filt (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .tick_i     (ms_tick),
    .level_i    (alarm_reset_i),
    .hold_ms_i  (alarm_reset_filter_time_i),
    .pulse_o    (reset_pulse)
  );

  // ==========================================================
  // State
  // ==========================================================
  seq_state_t         state_q, state_d;
  logic [DELAY_W-1:0] tmr_q, tmr_d;
  logic               alarm_q, alarm_d;
  logic               need_fresh_q, need_fresh_d;

  wire at_rest      = at_or_below(motor_speed_i, REST_SPEED);
  wire below_thresh = at_or_below(motor_speed_i, brake_speed_threshold_i);
  wire fault        = alarm_i || !main_power_ok_i;
  wire stop_expired = (tmr_q >= stop_brake_delay_i);
  wire run_expired  = (tmr_q >= run_brake_delay_i);
  wire tmr_step     = ms_tick && (tmr_q != {DELAY_W{1'b1}});

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    state_d      = state_q;
    tmr_d        = tmr_q;
    alarm_d      = alarm_q || fault;
    need_fresh_d = need_fresh_q;
    if (!servo_on_cmd_i) begin
      need_fresh_d = 1'b0;
    end
    unique case (state_q)
      ST_OFF: begin
        tmr_d = '0;
        if (alarm_q || fault) begin
          state_d = ST_ALARM;
        end else if (servo_on_cmd_i && !need_fresh_q) begin
          state_d = ST_WAIT_REST;
        end
      end
      ST_WAIT_REST: begin
        if (alarm_q || fault) begin
          state_d = ST_ALARM;
        end else if (!servo_on_cmd_i) begin
          state_d = ST_OFF;
        end else if (at_rest && below_thresh) begin
          state_d = ST_ON;
        end
      end
      ST_ON: begin
        tmr_d = '0;
        if (fault) begin
          state_d = ST_RUN_DELAY;
        end else if (!servo_on_cmd_i) begin
          state_d = at_rest ? ST_STOP_DELAY : ST_RUN_DELAY;
        end
      end
      ST_STOP_DELAY: begin
        if (tmr_step) begin
          tmr_d = tmr_q + 1'b1;
        end
        if (stop_expired) begin
          state_d = alarm_q ? ST_ALARM : ST_OFF;
        end
      end
      ST_RUN_DELAY: begin
        if (tmr_step) begin
          tmr_d = tmr_q + 1'b1;
        end
        if (run_expired || below_thresh) begin
          state_d = alarm_q ? ST_ALARM : ST_OFF;
        end
      end
      ST_ALARM: begin
        tmr_d = '0;
        if (reset_pulse && !fault) begin
          state_d      = ST_OFF;
          alarm_d      = 1'b0;
          need_fresh_d = 1'b1;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  wire powered  = (state_d == ST_ON) || (state_d == ST_STOP_DELAY) || (state_d == ST_RUN_DELAY);
  // Release stays up through the off delays so the brake closes as power goes
  wire release_d = powered && brake_release_req_i;
  wire db_d     = !powered && db_on(servo_off_stop_select_i, at_rest);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q                <= ST_OFF;
      tmr_q                  <= '0;
      alarm_q                <= 1'b0;
      need_fresh_q           <= 1'b1;
      brake_release_output_o <= 1'b0;
      motor_power_o          <= 1'b0;
      dynamic_brake_o        <= 1'b1;
      servo_ready_o          <= 1'b0;
      alarm_active_o         <= 1'b0;
    end else begin
      state_q                <= state_d;
      tmr_q                  <= tmr_d;
      alarm_q                <= alarm_d;
      need_fresh_q           <= need_fresh_d;
      brake_release_output_o <= release_d;
      motor_power_o          <= powered;
      dynamic_brake_o        <= db_d;
      servo_ready_o          <= (state_d == ST_ON);
      alarm_active_o         <= alarm_d;
    end
  end

endmodule : holding_brake_interlock_sequencer

// ===== verif/brake_seq_properties.sv
// Port-level checks for the holding brake sequencer
`timescale 1ns/1ns
module brake_seq_properties #(
  parameter int unsigned SPEED_W  = 16,
  parameter int unsigned REST_RPM = 30
) (
  // Clock, reset, commands, alarm input, speed and threshold
  input wire logic               core_clk_i,
  input wire logic               rst_i,
  input wire logic               servo_on_cmd_i,
  input wire logic               alarm_reset_i,
  input wire logic               brake_release_req_i,
  input wire logic               alarm_i,
  input wire logic [SPEED_W-1:0] motor_speed_i,
  input wire logic [SPEED_W-1:0] brake_speed_threshold_i,
  // Outputs watched
  input wire logic               brake_release_output_o,
  input wire logic               motor_power_o,
  input wire logic               dynamic_brake_o,
  input wire logic               servo_ready_o,
  input wire logic               alarm_active_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence off_twice_s;
    !servo_ready_o ##1 !servo_ready_o;
  endsequence
  release_req_a: assert property (brake_release_output_o |-> $past(brake_release_req_i))
    else $error("brake released without request");
  release_on_a: assert property (brake_release_output_o |-> motor_power_o)
    else $error("brake released with motor unpowered");
  rest_speed_a: assert property ($rose(servo_ready_o) |-> $past(motor_speed_i) <= REST_RPM)
    else $error("servo on above rest speed");
  thr_speed_a: assert property ($rose(servo_ready_o) |-> $past(motor_speed_i) <= $past(brake_speed_threshold_i))
    else $error("servo on above threshold");
  ready_cause_a: assert property ($rose(servo_ready_o) |-> $past(servo_on_cmd_i) && !$past(alarm_active_o))
    else $error("servo on without command");
  reset_cause_a: assert property ($fell(alarm_active_o) |-> $past(alarm_reset_i) && !$past(alarm_i))
    else $error("alarm cleared without reset");
  stay_off_a: assert property ($fell(alarm_active_o) |-> off_twice_s)
    else $error("servo on right after alarm reset");
  db_clear_a: assert property (servo_ready_o |-> !dynamic_brake_o)
    else $error("dynamic brake in servo on");
  ready_power_a: assert property (servo_ready_o |-> motor_power_o)
    else $error("servo on without power");
endmodule : brake_seq_properties

bind holding_brake_interlock_sequencer brake_seq_properties #(.SPEED_W(SPEED_W), .REST_RPM(REST_RPM)) chk (.*);

// ===== verif/host_ctrl_model.sv
// Host controller model driving servo on and alarm reset levels
`timescale 1ns/1ns
module host_ctrl_model (
  // Requests from bench
  input  wire logic core_clk_i,
  input  wire logic want_on_i,
  input  wire logic want_reset_i,
  input  wire logic alarm_active_i,
  // Levels to the sequencer
  output logic      servo_on_o = 1'b0,
  output logic      alarm_reset_o = 1'b0
);
  // Command drops while an alarm stands, so a later on is a fresh one
  always @(posedge core_clk_i) begin
    servo_on_o    <= want_on_i && !alarm_active_i;
    alarm_reset_o <= want_reset_i;
  end
endmodule : host_ctrl_model

// ===== verif/tb_holding_brake_interlock_sequencer.sv
// Self-checking bench for the holding brake sequencer
`timescale 1ns/1ns
module tb_holding_brake_interlock_sequencer;
  import brake_seq_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        want_on = 1'b0, want_rst = 1'b0, req = 1'b1, pwr_ok = 1'b1, alm_in = 1'b0, e;
  logic        servo_on, alarm_reset, rel_o, pwr_o, db_o, rdy_o, alm_o;
  logic [15:0] speed = 16'h0000, thr = 16'h0064, d_run = 16'h0032;
  logic [1:0]  sel = 2'h0;
  int          bad_count = 0;
  int          total_checks = 0;
  // Speed, threshold, expected servo on
  logic [32:0] rows [5] = '{{16'h0000, 16'h0064, 1'b1}, {16'h001E, 16'h0064, 1'b1},
    {16'h001F, 16'h0064, 1'b0}, {16'h0014, 16'h000A, 1'b0}, {16'h000A, 16'h000A, 1'b1}};
  always #25 core_clk_i = ~core_clk_i;
  host_ctrl_model host (.core_clk_i(core_clk_i), .want_on_i(want_on), .want_reset_i(want_rst),
    .alarm_active_i(alm_o), .servo_on_o(servo_on), .alarm_reset_o(alarm_reset));
  // Short ms tick keeps delays of a few ms to tens of cycles
  holding_brake_interlock_sequencer #(.MS_CYCLES(10)) DUT (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .servo_on_cmd_i(servo_on), .alarm_reset_i(alarm_reset), .brake_release_req_i(req),
    .motor_speed_i(speed), .alarm_i(alm_in), .main_power_ok_i(pwr_ok), .stop_brake_delay_i(16'h0003),
    .run_brake_delay_i(d_run), .brake_speed_threshold_i(thr), .servo_off_stop_select_i(sel),
    .alarm_reset_filter_time_i(16'h0003), .brake_release_output_o(rel_o), .motor_power_o(pwr_o),
    .dynamic_brake_o(db_o), .servo_ready_o(rdy_o), .alarm_active_o(alm_o));
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : cyc
  task automatic chk(input string what, input logic ex, input logic got);
    total_checks++;
    if (got !== ex) begin
      bad_count++;
      $display("BAD %s expected %b seen %b", what, ex, got);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  initial begin
    #1000000;
    bad_count++;
    give_verdict();
  end
  initial begin
    cyc(8);
    rst_i = 1'b0;
    chk("release", 1'b0, rel_o);
    chk("power", 1'b0, pwr_o);
    chk("dbrake", 1'b1, db_o);
    chk("alarm", 1'b0, alm_o);
    for (int i = 0; i < 5; i++) begin
      {speed, thr, e} = rows[i];
      want_on = 1'b1;
      cyc(5);
      chk("ready", e, rdy_o);
      chk("release", e, rel_o);
      want_on = 1'b0;
      speed = 16'h0000;
      cyc(60);
    end
    // Standstill off: request comes late, release then held with power for the stop delay
    req = 1'b0;
    thr = 16'h0064;
    want_on = 1'b1;
    cyc(5);
    chk("release", 1'b0, rel_o);
    chk("ready", 1'b1, rdy_o);
    want_on = 1'b0;
    req = 1'b1;
    cyc(25);
    chk("power", 1'b1, pwr_o);
    chk("release", 1'b1, rel_o);
    cyc(20);
    chk("power", 1'b0, pwr_o);
    chk("release", 1'b0, rel_o);
    for (int s = 0; s < 4; s++) begin
      sel = s[1:0];
      d_run = (s == 3) ? 16'h0002 : 16'h0032;
      want_on = 1'b1;
      cyc(5);
      speed = 16'h01F4;
      cyc(2);
      want_on = 1'b0;
      cyc(5);
      chk("power", 1'b1, pwr_o);
      chk("release", 1'b1, rel_o);
      chk("dbrake", 1'b0, db_o);
      want_on = 1'b1;
      cyc(5);
      chk("ready", 1'b0, rdy_o);
      want_on = 1'b0;
      if (s == 3) cyc(30);
      else speed = 16'h005A;
      cyc(3);
      chk("power", 1'b0, pwr_o);
      chk("release", 1'b0, rel_o);
      chk("dbrake", !sel[1], db_o);
      speed = 16'h0000;
      cyc(50);
      chk("dbrake", !sel[0], db_o);
    end
    want_on = 1'b1;
    cyc(5);
    pwr_ok = 1'b0;
    cyc(3);
    chk("alarm", 1'b1, alm_o);
    chk("release", 1'b0, rel_o);
    pwr_ok = 1'b1;
    want_on = 1'b0;
    want_rst = 1'b1;
    cyc(15);
    want_rst = 1'b0;
    cyc(2);
    chk("alarm", 1'b1, alm_o);
    want_rst = 1'b1;
    cyc(60);
    chk("alarm", 1'b0, alm_o);
    chk("ready", 1'b0, rdy_o);
    want_rst = 1'b0;
    want_on = 1'b1;
    cyc(5);
    chk("ready", 1'b1, rdy_o);
    // Reset in mid-run with servo on still held: a fresh command is needed
    rst_i = 1'b1;
    cyc(2);
    chk("release", 1'b0, rel_o);
    chk("power", 1'b0, pwr_o);
    chk("ready", 1'b0, rdy_o);
    rst_i = 1'b0;
    cyc(10);
    chk("ready", 1'b0, rdy_o);
    want_on = 1'b0;
    cyc(2);
    want_on = 1'b1;
    cyc(5);
    chk("ready", 1'b1, rdy_o);
    // Alarm input in servo on; a held reset is refused while the alarm stands
    alm_in = 1'b1;
    want_on = 1'b0;
    cyc(3);
    chk("alarm", 1'b1, alm_o);
    chk("power", 1'b0, pwr_o);
    want_rst = 1'b1;
    cyc(50);
    chk("alarm", 1'b1, alm_o);
    give_verdict();
  end
endmodule : tb_holding_brake_interlock_sequencer
